// ==== seq_defines.svh ====
// Constants for the positioning sequencer: sizes, codes, limits.
// Included by seq_pkg.sv, positioning_sequencer.sv and the checker.
`ifndef SEQ_DEFINES_SVH
`define SEQ_DEFINES_SVH
`define ENTRY_COUNT 63
`define LAST_ENTRY 6'h3f
`define CHAIN_MAX 3'h4
`define PROFILE_COUNT 4
`define UNIT_COARSE_NM 10_000
`define UNIT_FINE_NM 1_000
// Push speed limit, 25 mm/s in 0.01 mm/s units
`define PUSH_SPEED_MAX 24'h00_09c4
`define NVM_ENDURANCE 100_000
`endif

// ==== seq_pkg.sv ====
// Types for the positioning sequencer.
// Assumes seq_defines.svh sits in the same folder.
`include "seq_defines.svh"
package seq_pkg;
    typedef enum logic [1:0] {
        FN_UNSET = 2'b00,
        FN_SINGLE = 2'b01,
        FN_LINKED = 2'b10,
        FN_PUSH = 2'b11
    } func_t;
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_MOVE = 2'b01,
        ST_WAIT = 2'b10
    } state_t;
endpackage : seq_pkg

// ==== positioning_sequencer.sv ====
// Positioning sequencer: entry table, single and linked moves,
// sequence-forward stepping, absolute and incremental targets, preset.
// Assumes a motion engine that takes one segment and reports done.
`timescale 1ns/100ps
`default_nettype none
`include "seq_defines.svh"

// How it works
// - Preset input loads current position as preset
// - Absolute preset pulses a nonvolatile write
// - Table holds entries one through sixty-three
// - Entry: mode, distance, speed, function, profile
// - One starting speed shared by all entries
// - Profile index picks one of four combinations
// - Absolute target is distance from home
// - Incremental target adds to current position
// - Unit 0.01 mm, fine models 0.001 mm
// - Start runs the entry on select inputs
// - Single entry moves its distance then stops
// - Linked start runs up to four entries
// - Linked entry sixty-three runs as single
// - First entry's profile governs whole chain
// - Linked fourth entry raises bad data alarm
// - Push segment ending a linked chain runs at starting speed
// - Direction change ends the linked chain
// - Select zero enters sequence-forward mode
// - Each start runs next step; chain counts once
// - Listed events restart sequence at entry one
// - Push above 25 mm/s raises alarm instead
module positioning_sequencer
    import seq_pkg::*;
#(
    parameter int POS_W = 24,
    parameter int SPD_W = 24
) (
    // Clock and reset
    input wire logic clk,
    input wire logic reset,
    // Table write port
    input wire logic wr_en,
    input wire logic [5:0] wr_index,
    input wire logic wr_abs,
    input wire logic signed [POS_W-1:0] wr_distance,
    input wire logic [SPD_W-1:0] wr_speed,
    input wire logic [1:0] wr_func,
    input wire logic [1:0] wr_profile,
    // Shared configuration
    input wire logic [SPD_W-1:0] start_speed,
    input wire logic fine_pitch,
    input wire logic preset_selected,
    input wire logic absolute_mode,
    // Host inputs
    input wire logic start,
    input wire logic [5:0] data_select_inputs,
    input wire logic preset,
    input wire logic alarm_reset,
    input wire logic estop_release,
    input wire logic stop,
    input wire logic continuous_op,
    input wire logic release_hold,
    input wire logic pendant_external_mode,
    // Motion engine
    input wire logic seg_done,
    input wire logic signed [POS_W-1:0] actual_position,
    // Motion engine command
    output logic seg_valid,
    output logic signed [POS_W-1:0] seg_target,
    output logic [SPD_W-1:0] seg_speed,
    output logic [1:0] seg_profile,
    output logic seg_push,
    output logic seg_last,
    output logic [15:0] unit_nm,
    // Status
    output logic busy,
    output logic [5:0] seq_pointer,
    output logic bad_operating_data_alarm,
    output logic signed [POS_W-1:0] preset_position,
    output logic nvm_write
);
    // Entry table; index 0 unused
    logic abs_mem [1:`ENTRY_COUNT];
    logic signed [POS_W-1:0] dist_mem [1:`ENTRY_COUNT];
    logic [SPD_W-1:0] spd_mem [1:`ENTRY_COUNT];
    func_t func_mem [1:`ENTRY_COUNT];
    logic [1:0] prof_mem [1:`ENTRY_COUNT];

    state_t state_r;
    state_t state_nxt;
    logic [5:0] cur_r;
    logic [5:0] cur_nxt;
    logic [2:0] depth_r;
    logic [2:0] depth_nxt;
    logic [1:0] chain_prof_r;
    logic signed [POS_W-1:0] base_r;
    logic dir_r;
    logic pend_r;
    logic ext_d_r;

    // Entry decode for the entry about to run
    // Entry 0 is never fetched; cur_ok guards every table read
    wire logic cur_ok = (cur_r != 6'h00);
    wire logic cur_abs = cur_ok ? abs_mem[cur_r] : 1'b0;
    wire logic signed [POS_W-1:0] cur_dist =
        cur_ok ? dist_mem[cur_r] : '0;
    wire logic [SPD_W-1:0] cur_spd = cur_ok ? spd_mem[cur_r] : '0;
    wire func_t cur_fn_raw = cur_ok ? func_mem[cur_r] : FN_UNSET;
    wire logic [1:0] cur_prof = cur_ok ? prof_mem[cur_r] : 2'b00;
    wire logic cur_is_63 = (cur_r == `LAST_ENTRY);
    wire func_t cur_fn = (cur_is_63 && cur_fn_raw == FN_LINKED) ?
        FN_SINGLE : cur_fn_raw;
    wire logic signed [POS_W-1:0] cur_target = cur_abs ?
        cur_dist : base_r + cur_dist;
    // Equal target counts as forward, so a null step splits only a reverse chain
    wire logic cur_dir = (cur_target < base_r);
    wire logic first_seg = (depth_r == 3'h0);
    wire logic dir_break = !first_seg && (cur_dir != dir_r);
    wire logic fourth_linked = (depth_r == 3'h3) &&
        (cur_fn == FN_LINKED);
    wire logic push_fast = (cur_fn == FN_PUSH) &&
        (cur_spd > `PUSH_SPEED_MAX);
    wire logic bad_data = fourth_linked || push_fast;
    wire logic links_on = (cur_fn == FN_LINKED) && !fourth_linked;
    wire logic [5:0] nxt_entry = cur_r + 6'h01;
    wire func_t nxt_fn = (cur_is_63 || !cur_ok) ?
        FN_UNSET : func_mem[nxt_entry];

    // Sequence pointer restart events
    wire logic ext_left = ext_d_r && !pendant_external_mode;
    wire logic preset_evt = preset && preset_selected;
    wire logic seq_restart = alarm_reset || estop_release || stop ||
        preset_evt || continuous_op || release_hold || ext_left;
    wire logic seq_mode = (data_select_inputs == 6'h00);
    wire logic [5:0] launch_entry = seq_mode ? seq_pointer :
        data_select_inputs;
    // Stop-type events also end a run; preset only restarts stepping
    wire logic abort = stop || alarm_reset || estop_release ||
        continuous_op || release_hold;

    // A start is taken only while idle, alarm clear, entry nonzero
    wire logic start_ok = start && !bad_operating_data_alarm &&
        launch_entry != 6'h00;
    // Chain splits at a direction change, next sequence-forward start resumes
    wire logic move_end = bad_data || !cur_ok || cur_fn == FN_UNSET ||
        dir_break;

    // Table write, entries 1..63 only
    // Only the function field is cleared: an unwritten entry must read
    // as unset so stepping wraps; its other fields are then unused
    always_ff @(posedge clk) begin
        if (reset) begin
            for (int i = 1; i <= `ENTRY_COUNT; i++) begin
                func_mem[i] <= FN_UNSET;
            end
        end else if (wr_en && wr_index != 6'h00) begin
            abs_mem[wr_index] <= wr_abs;
            dist_mem[wr_index] <= wr_distance;
            spd_mem[wr_index] <= wr_speed;
            func_mem[wr_index] <= func_t'(wr_func);
            prof_mem[wr_index] <= wr_profile;
        end
    end

    // Sequencer control
    always_comb begin
        state_nxt = state_r;
        cur_nxt = cur_r;
        depth_nxt = depth_r;
        case (state_r)
            ST_IDLE: begin
                if (start_ok) begin
                    cur_nxt = launch_entry;
                    depth_nxt = 3'h0;
                    state_nxt = ST_MOVE;
                end
            end
            ST_MOVE: begin
                if (move_end) begin
                    state_nxt = ST_IDLE;
                end else begin
                    state_nxt = ST_WAIT;
                end
            end
            ST_WAIT: begin
                if (seg_done) begin
                    if (pend_r) begin
                        cur_nxt = nxt_entry;
                        depth_nxt = depth_r + 3'h1;
                        state_nxt = ST_MOVE;
                    end else begin
                        state_nxt = ST_IDLE;
                    end
                end
            end
            default: state_nxt = ST_IDLE;
        endcase
        if (abort) begin
            state_nxt = ST_IDLE;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            state_r <= ST_IDLE;
            cur_r <= 6'h00;
            depth_r <= 3'h0;
        end else begin
            state_r <= state_nxt;
            cur_r <= cur_nxt;
            depth_r <= depth_nxt;
        end
    end

    // Segment issue and chain bookkeeping
    wire logic issue = (state_r == ST_MOVE) && !abort && cur_ok &&
        cur_fn != FN_UNSET && !bad_data && !dir_break;
    wire logic [1:0] issue_prof = first_seg ? cur_prof :
        chain_prof_r;
    // A lone push keeps its own speed; at a chain end it slows down
    wire logic [SPD_W-1:0] issue_spd =
        (cur_fn == FN_PUSH && !first_seg) ? start_speed : cur_spd;

    wire logic issue_push = (cur_fn == FN_PUSH);

    // Command outputs other than seg_valid hold their value until the next issue
    always_ff @(posedge clk) begin
        if (reset) begin
            seg_valid <= 1'b0;
            seg_target <= '0;
            seg_speed <= '0;
            seg_profile <= 2'b00;
            seg_push <= 1'b0;
            seg_last <= 1'b0;
        end else begin
            seg_valid <= issue;
            if (issue) begin
                seg_target <= cur_target;
                seg_speed <= issue_spd;
                seg_profile <= issue_prof;
                seg_push <= issue_push;
                seg_last <= !links_on;
            end
        end
    end

    // Chain bookkeeping; base follows the last target, not the engine,
    // so an incremental chain never adds a stale position
    always_ff @(posedge clk) begin
        if (reset) begin
            chain_prof_r <= 2'b00;
            base_r <= '0;
            dir_r <= 1'b0;
            pend_r <= 1'b0;
        end else if (issue) begin
            chain_prof_r <= issue_prof;
            base_r <= cur_target;
            dir_r <= cur_dir;
            pend_r <= links_on;
        end else if (state_r == ST_IDLE) begin
            base_r <= actual_position;
        end
    end

    // Sequence-forward pointer
    // Pointer also moves in selected mode; only stepping reads it
    wire logic run_ends = (state_r == ST_WAIT) && seg_done && !pend_r;
    wire logic split_ends = (state_r == ST_MOVE) && dir_break && !abort;
    wire logic [5:0] ptr_after = (nxt_fn == FN_UNSET) ?
        6'h01 : nxt_entry;

    always_ff @(posedge clk) begin
        if (reset) begin
            seq_pointer <= 6'h01;
        end else begin
            if (seq_restart) begin
                seq_pointer <= 6'h01;
            end else if (split_ends) begin
                seq_pointer <= cur_r;
            end else if (run_ends) begin
                seq_pointer <= ptr_after;
            end
        end
    end

    // Mode history; only a falling edge of the pendant mode restarts
    always_ff @(posedge clk) begin
        if (reset) begin
            ext_d_r <= 1'b0;
        end else begin
            ext_d_r <= pendant_external_mode;
        end
    end

    // Alarm, preset, status
    wire logic alarm_set = (state_r == ST_MOVE) && bad_data;
    // Set wins over a clear in the same cycle
    wire logic alarm_nxt = alarm_set ||
        (bad_operating_data_alarm && !alarm_reset);
    // Each pulse costs one nonvolatile write cycle; a held preset
    // writes on every cycle, so the host must keep it short
    wire logic nvm_nxt = preset_evt && absolute_mode;
    // Busy looks ahead so it rises on the edge that takes start
    wire logic busy_nxt = (state_nxt != ST_IDLE);
    wire logic [15:0] unit_nxt = fine_pitch ?
        16'(`UNIT_FINE_NM) : 16'(`UNIT_COARSE_NM);

    always_ff @(posedge clk) begin
        if (reset) begin
            bad_operating_data_alarm <= 1'b0;
        end else begin
            bad_operating_data_alarm <= alarm_nxt;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            preset_position <= '0;
        end else if (preset_evt) begin
            preset_position <= actual_position;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            nvm_write <= 1'b0;
            busy <= 1'b0;
        end else begin
            nvm_write <= nvm_nxt;
            busy <= busy_nxt;
        end
    end

    // Unit is registered; it follows fine_pitch one cycle later, even while a move runs
    always_ff @(posedge clk) begin
        if (reset) begin
            unit_nm <= 16'(`UNIT_COARSE_NM);
        end else begin
            unit_nm <= unit_nxt;
        end
    end
endmodule : positioning_sequencer
`default_nettype wire

// ==== positioning_sequencer_chk.sv ====
// Checker on the sequencer ports.
// Assumes one clock and a synchronous reset.
`timescale 1ns/100ps
`default_nettype none
`include "seq_defines.svh"
module positioning_sequencer_chk #(
    parameter int POS_W = 24,
    parameter int SPD_W = 24
) (
    // Inputs
    input wire logic clk,
    input wire logic reset,
    input wire logic fine_pitch,
    input wire logic preset,
    input wire logic preset_selected,
    input wire logic absolute_mode,
    input wire logic alarm_reset,
    input wire logic estop_release,
    input wire logic stop,
    input wire logic continuous_op,
    input wire logic release_hold,
    input wire logic pendant_external_mode,
    input wire logic seg_done,
    input wire logic signed [POS_W-1:0] actual_position,
    // Outputs
    input wire logic seg_valid,
    input wire logic [SPD_W-1:0] seg_speed,
    input wire logic seg_push,
    input wire logic seg_last,
    input wire logic [15:0] unit_nm,
    input wire logic busy,
    input wire logic [5:0] seq_pointer,
    input wire logic bad_operating_data_alarm,
    input wire logic signed [POS_W-1:0] preset_position,
    input wire logic nvm_write
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (reset);
    a_seg_one_cycle: assert property (seg_valid |=> !seg_valid)
        else $error("segment strobe too long");
    a_last_ends_run: assert property (seg_done && seg_last |=> !busy)
        else $error("busy after last segment");
    a_unit_size: assert property
        (1'b1 |=> unit_nm == ($past(fine_pitch) ? 16'h03e8 : 16'h2710))
        else $error("wrong position unit");
    a_preset_load: assert property (preset && preset_selected |=>
        preset_position == $past(actual_position))
        else $error("preset not loaded");
    a_nvm_pulse: assert property (preset && preset_selected &&
        absolute_mode |=> nvm_write ##1 !nvm_write)
        else $error("bad store pulse");
    a_alarm_sticky: assert property (bad_operating_data_alarm &&
        !alarm_reset |=> bad_operating_data_alarm)
        else $error("alarm dropped");
    a_push_limit: assert property (seg_valid && seg_push |->
        seg_speed <= `PUSH_SPEED_MAX)
        else $error("push too fast");
    a_restart_ptr: assert property (stop || alarm_reset ||
        (preset && preset_selected) ||
        estop_release || continuous_op || release_hold ||
        $fell(pendant_external_mode) |=> seq_pointer == 6'h01)
        else $error("pointer not restarted");
    a_ptr_range: assert property (seq_pointer != 6'h00)
        else $error("pointer zero");
endmodule : positioning_sequencer_chk
bind positioning_sequencer positioning_sequencer_chk #(.POS_W(POS_W),
    .SPD_W(SPD_W)) chk (.clk, .reset, .fine_pitch, .preset,
    .preset_selected, .absolute_mode, .alarm_reset, .estop_release, .stop,
    .continuous_op, .release_hold, .pendant_external_mode, .seg_done,
    .actual_position, .seg_valid, .seg_speed, .seg_push, .seg_last,
    .unit_nm, .busy, .seq_pointer, .bad_operating_data_alarm,
    .preset_position, .nvm_write);
`default_nettype wire

// ==== motion_engine.sv ====
// Motion engine model: runs one segment, then reports done.
// Assumes one segment at a time; slow stretches each move.
`timescale 1ns/100ps
`default_nettype none
module motion_engine #(parameter int POS_W = 24) (
    // Clock and pace
    input wire logic clk,
    input wire logic reset,
    input wire logic slow,
    // Segment handshake
    input wire logic seg_valid,
    input wire logic signed [POS_W-1:0] seg_target,
    output logic seg_done,
    output logic signed [POS_W-1:0] actual_position
);
    logic [3:0] cnt_r;
    always_ff @(posedge clk) begin
        seg_done <= 1'b0;
        if (reset) begin
            cnt_r <= 4'h0;
            actual_position <= '0;
        end else if (seg_valid) begin
            cnt_r <= slow ? 4'h9 : 4'h1;
        end else if (cnt_r == 4'h1) begin
            cnt_r <= 4'h0;
            seg_done <= 1'b1;
            actual_position <= seg_target;
        end else if (cnt_r != 4'h0) begin
            cnt_r <= cnt_r - 4'h1;
        end
    end
endmodule : motion_engine
`default_nettype wire

// ==== tb_top.sv ====
// Testbench: moves, chains, sequence stepping, preset.
// Assumes the sequencer, checker and engine compile first.
`timescale 1ns/100ps
`default_nettype none
module tb_top;
    import seq_pkg::*;
    logic clk, reset, wr_en, wr_abs, start, slow, fine_pitch, busy;
    logic preset_selected, absolute_mode, seg_valid, seg_push, seg_last;
    logic nvm_write, seg_done, bad_operating_data_alarm;
    logic [5:0] wr_index, data_select_inputs, seq_pointer;
    logic signed [23:0] wr_distance, actual_position, seg_target;
    logic signed [23:0] preset_position;
    logic [23:0] wr_speed, start_speed, seg_speed, tq[$];
    logic [1:0] wr_func, wr_profile, seg_profile, pq[$];
    logic [15:0] unit_nm;
    logic [6:0] ev;
    wire pendant_external_mode, preset, release_hold, continuous_op;
    wire estop_release, stop, alarm_reset;
    int errors, total_checks, nw;
    assign {pendant_external_mode, preset, release_hold, continuous_op,
        estop_release, stop, alarm_reset} = ev;
    positioning_sequencer DUT (.clk, .reset, .wr_en, .wr_index, .wr_abs,
        .wr_distance, .wr_speed, .wr_func, .wr_profile, .start_speed,
        .fine_pitch, .preset_selected, .absolute_mode, .start,
        .data_select_inputs, .preset, .alarm_reset, .estop_release, .stop,
        .continuous_op, .release_hold, .pendant_external_mode, .seg_done,
        .actual_position, .seg_valid, .seg_target, .seg_speed,
        .seg_profile, .seg_push, .seg_last, .unit_nm, .busy, .seq_pointer,
        .bad_operating_data_alarm, .preset_position, .nvm_write);
    motion_engine eng (.clk, .reset, .slow, .seg_valid, .seg_target,
        .seg_done, .actual_position);
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    always @(posedge clk) begin
        if (seg_valid === 1'b1) begin
            tq.push_back(seg_target);
            pq.push_back(seg_profile);
        end
        if (nvm_write === 1'b1) nw++;
    end
    task automatic check(input string what, input logic [31:0] got, exp);
        total_checks++;
        if (got !== exp) begin
            errors++;
            $display("unexpected %s: expected %h seen %h", what, exp, got);
        end
    endtask : check
    task automatic wr(input logic [5:0] i, input logic a,
        input logic [23:0] d, input logic [1:0] f);
        @(negedge clk);
        {wr_en, wr_index, wr_abs, wr_distance} = {1'b1, i, a, d};
        wr_func = f;
        wr_profile = i[1:0];
        @(negedge clk);
        wr_en = 1'b0;
    endtask : wr
    // Start, then wait for idle; a refused start never raises busy
    task automatic go(input logic [5:0] sel);
        int n;
        tq.delete();
        pq.delete();
        @(negedge clk);
        data_select_inputs = sel;
        start = 1'b1;
        @(negedge clk);
        start = 1'b0;
        n = 0;
        while (busy !== 1'b0 && n < 200) begin
            @(negedge clk);
            n++;
        end
    endtask : go
    task automatic pulse(input logic [6:0] b);
        @(negedge clk);
        ev = b;
        @(negedge clk);
        ev = '0;
        @(negedge clk);
    endtask : pulse
    task automatic t_moves;
        check("unit", unit_nm, 16'h2710);
        wr(6'h02, 1'b1, 24'h03e8, FN_SINGLE);
        go(6'h02);
        check("tgt", tq[0], 24'h03e8);
        check("cnt", tq.size(), 1);
        check("prof", seg_profile, 2'h2);
        wr(6'h05, 1'b0, 24'h012c, FN_SINGLE);
        go(6'h05);
        check("inc", tq[0], 24'h0514);
        wr(6'h3f, 1'b1, 24'h0dac, FN_LINKED);
        go(6'h3f);
        check("cnt63", tq.size(), 1);
    endtask : t_moves
    task automatic t_chain;
        slow = 1'b1;
        wr(6'h09, 1'b1, 24'h0e10, FN_LINKED);
        wr(6'h0a, 1'b1, 24'h0e74, FN_LINKED);
        wr_speed = 24'h0258;
        wr(6'h0b, 1'b1, 24'h0ed8, FN_PUSH);
        wr_speed = 24'h0fa0;
        go(6'h09);
        slow = 1'b0;
        check("cnt", tq.size(), 3);
        check("prof", pq[2], 2'h1);
        check("push", {seg_push, seg_speed}, 25'h100_012c);
        wr(6'h1e, 1'b1, 24'h0fa0, FN_LINKED);
        wr(6'h1f, 1'b1, 24'h0064, FN_SINGLE);
        go(6'h1e);
        check("dir", tq.size(), 1);
    endtask : t_chain
    task automatic t_alarm;
        for (int i = 0; i < 4; i++) begin
            wr(6'(20 + i), 1'b1, 24'h1004 + 24'(i * 100), FN_LINKED);
        end
        go(6'h14);
        check("alarm", bad_operating_data_alarm, 1'b1);
        check("cnt", tq.size(), 3);
        pulse(7'h01);
        wr(6'h28, 1'b1, 24'h1130, FN_PUSH);
        wr_speed = 24'h09c5;
        wr(6'h28, 1'b1, 24'h1130, FN_PUSH);
        wr_speed = 24'h0fa0;
        go(6'h28);
        check("fast", {tq.size(), bad_operating_data_alarm}, 33'h1);
        pulse(7'h01);
    endtask : t_alarm
    task automatic t_seq;
        wr(6'h01, 1'b1, 24'h03e8, FN_SINGLE);
        wr(6'h02, 1'b0, 24'h0032, FN_SINGLE);
        go(6'h00);
        check("seq1", {seq_pointer, tq[0]}, {6'h02, 24'h03e8});
        go(6'h00);
        check("seq2", {seq_pointer, tq[0]}, {6'h01, 24'h041a});
        for (int i = 0; i < 7; i++) begin
            go(6'h00);
            pulse(7'h01 << i);
            check("ptr", seq_pointer, 6'h01);
        end
        {absolute_mode, fine_pitch} = 2'h3;
        pulse(7'h20);
        check("pre", preset_position, 24'h03e8);
        check("nvm", nw, 1);
        check("fine", unit_nm, 16'h03e8);
    endtask : t_seq
    task automatic final_report;
        $display("checks %0d errors %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : final_report
    initial begin
        {wr_en, wr_abs, start, slow, fine_pitch, absolute_mode, ev} = '0;
        {wr_index, data_select_inputs, wr_distance, wr_func} = '0;
        {wr_profile, preset_selected, reset} = 4'h3;
        wr_speed = 24'h0fa0;
        start_speed = 24'h012c;
        repeat (2) @(negedge clk);
        reset = 1'b0;
        t_moves();
        t_chain();
        t_alarm();
        t_seq();
        final_report();
    end
    initial begin
        repeat (20000) @(posedge clk);
        errors++;
        final_report();
    end
endmodule : tb_top
`default_nettype wire
